//--- hdl/pstc_pkg.sv
// Purpose: shared constants and types for the pad state controller
// Assumes: 12 switchable pads, one wake pad, two mixed-signal pads
// Notes: register block sits on AXI4-Lite with 32-bit data
package pstc_pkg;
  // pad map: [11:0] switchable, [12] wake, [14:13] mixed-signal
  localparam int NP = 15;
  localparam int NSW = 12;
  localparam int WAKE_IDX = 12;
  localparam int MIX_LO = 13;
  localparam int NM = 2;
  localparam int AW = 5;
  localparam int SYW = NP + 4;
  localparam logic [AW-1:0] OFS_CTRL = 5'h00;
  localparam logic [AW-1:0] OFS_OE = 5'h04;
  localparam logic [AW-1:0] OFS_DOUT = 5'h08;
  localparam logic [AW-1:0] OFS_PULL_EN = 5'h0c;
  localparam logic [AW-1:0] OFS_PULL_UP = 5'h10;
  localparam logic [AW-1:0] OFS_ANA_SEL = 5'h14;
  localparam logic [AW-1:0] OFS_STATUS = 5'h18;
  localparam logic [AW-1:0] OFS_PAD_IN = 5'h1c;
  localparam int CTRL_PROG_BIT = 0;
  localparam int STS_OFF_BIT = 0;
  localparam int STS_RST_BIT = 1;
  localparam int STS_DEF_BIT = 2;
  localparam int STS_SLP_BIT = 3;
  localparam int STS_ACT_BIT = 4;
  localparam int STS_WAKE_BIT = 5;
  localparam int STS_RADIO_BIT = 6;
  localparam logic [NP-1:0] CFG_RST = 15'h0000;
  localparam logic [NM-1:0] ANA_RST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // reset pulse: 256 periods of the 2 MHz clock divided by 64
  localparam int CLK_PERIOD_NS = 25;
  localparam int SLOW_PERIOD_NS = 500;
  localparam int LP_DIV = 64;
  localparam int RST_PERIODS = 256;
  localparam int RST_TIME_NS = RST_PERIODS * LP_DIV * SLOW_PERIOD_NS;
  localparam int RST_CYCLES_DEF =
    (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCNT_W = 20;
  typedef enum logic [2:0] {
    ST_OFF, ST_RESET, ST_DEFAULT, ST_SLEEP, ST_ACTIVE
  } pstc_state_t;
  typedef struct packed {
    logic oe;
    logic ie;
    logic pe;
    logic pu;
    logic dout;
  } pstc_pin_t;
endpackage

//--- hdl/pstc_cfg_if.sv
// Purpose: per-pad drive settings between controller and hold bank
// Assumes: one bit per pad in each vector
// Notes: src drives the settings, dst reads them
`timescale 1ns/1ps
interface pstc_cfg_if;
  import pstc_pkg::*;
  logic [NP-1:0] oe;
  logic [NP-1:0] dout;
  logic [NP-1:0] pe;
  logic [NP-1:0] pu;
  modport src (output oe, output dout, output pe, output pu);
  modport dst (input oe, input dout, input pe, input pu);
endinterface

//--- hdl/pstc_hold.sv
// Purpose: retention bank for pad settings across sleep
// Assumes: track is high whenever the switchable pads follow live settings
// Notes: held values come straight from flip-flops
`timescale 1ns/1ps
module pstc_hold (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic track,
  pstc_cfg_if.dst live,
  pstc_cfg_if.src held
);
  import pstc_pkg::*;
  typedef struct packed {
    logic [NP-1:0] oe;
    logic [NP-1:0] dout;
    logic [NP-1:0] pe;
    logic [NP-1:0] pu;
  } pstc_hold_t;
  pstc_hold_t q_ff;
  pstc_hold_t nxt_q;
  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_q = q_ff;
    if (track) begin
      nxt_q.oe = live.oe;
      nxt_q.dout = live.dout;
      nxt_q.pe = live.pe;
      nxt_q.pu = live.pu;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_ff <= '0;
    end else if (ce) begin
      q_ff <= nxt_q;
    end
  end
  assign held.oe = q_ff.oe;
  assign held.dout = q_ff.dout;
  assign held.pe = q_ff.pe;
  assign held.pu = q_ff.pu;
endmodule

//--- hdl/pstc_top.sv
// Purpose: pad controller that sets each pad by device power state
// Assumes: power inputs and pad inputs are asynchronous to aclk
// Notes: registers over AXI4-Lite, one aligned word each
//
// What this block does
// RULE1 - core off with enable low: all pads hi-z, no input, no pull
// RULE2 - reset pulse: pads hi-z, input off, pull only on wake pad
// RULE3 - unprogrammed digital pads: hi-z, input on, pull-up on
// RULE4 - unprogrammed mixed pads: analog, input and pull off
// RULE5 - active: firmware sets oe, level, pull enable, pull direction
// RULE6 - active and sleep: input buffer on exactly when driver off
// RULE7 - sleep: switchable pads keep last drive and pull settings
// RULE8 - sleep: wake pad keeps following live settings
// RULE9 - mixed pads select analog or digital; analog disables all
// RULE10 - analog selection overrides retention in sleep
// RULE11 - wake pin high blocks sleep; low sleeps when radio idle
// RULE12 - reset held 256 periods of the slow clock divided by 64 after power-on or brown-out
// RULE13 - state priority: off, reset, default, sleep, active
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
module pstc_top #(
  parameter int RST_CYCLES = pstc_pkg::RST_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [pstc_pkg::AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [pstc_pkg::AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic io_supply,
  input wire logic chip_en,
  input wire logic por_bod,
  input wire logic radio_events_pending,
  input wire logic [pstc_pkg::NP-1:0] pad_in,
  output logic [pstc_pkg::NP-1:0] pad_out,
  output logic [pstc_pkg::NP-1:0] pad_oe,
  output logic [pstc_pkg::NP-1:0] pad_ie,
  output logic [pstc_pkg::NP-1:0] pad_pe,
  output logic [pstc_pkg::NP-1:0] pad_pu,
  output logic [pstc_pkg::NM-1:0] pad_analog,
  output logic radio_active_state,
  output logic sleep_enter
);
  import pstc_pkg::*;
  typedef struct packed {
    pstc_state_t st;
    logic [RCNT_W-1:0] rcnt;
    logic prog;
    logic [NP-1:0] c_oe;
    logic [NP-1:0] c_out;
    logic [NP-1:0] c_pe;
    logic [NP-1:0] c_pu;
    logic [NM-1:0] ana;
    logic [NP-1:0] p_oe;
    logic [NP-1:0] p_out;
    logic [NP-1:0] p_ie;
    logic [NP-1:0] p_pe;
    logic [NP-1:0] p_pu;
    logic [NM-1:0] p_ana;
    logic radio_o;
    logic sleep_o;
    logic [SYW-1:0] sy1;
    logic [SYW-1:0] sy2;
    logic aw_h;
    logic [AW-1:0] aw_a;
    logic w_h;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } pstc_top_t;
  localparam logic [RCNT_W-1:0] RCNT_LAST = RCNT_W'(RST_CYCLES - 1);
  pstc_top_t q_ff;
  pstc_top_t nxt_q;
  pstc_cfg_if live_if ();
  pstc_cfg_if held_if ();
  logic [NP-1:0] pin_s;
  logic io_s;
  logic en_s;
  logic por_s;
  logic rad_s;
  logic off_s;
  logic sleep_req;
  ////////////////////////////////////////////////////////////////////////
  // byte-lane merge of a write into a register
  function automatic logic [31:0] wr_lanes(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction
  // digital drive with input buffer opposite the driver
  function automatic pstc_pin_t pin_drv(input logic oe, input logic dout,
                                        input logic pe, input logic pu);
    pstc_pin_t p;
    p.oe = oe;
    p.ie = ~oe; // RULE6
    p.pe = pe;
    p.pu = pu;
    p.dout = dout;
    return p;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  assign pin_s = q_ff.sy2[NP-1:0];
  assign io_s = q_ff.sy2[NP];
  assign en_s = q_ff.sy2[NP+1];
  assign por_s = q_ff.sy2[NP+2];
  assign rad_s = q_ff.sy2[NP+3];
  assign off_s = io_s & ~en_s;
  assign sleep_req = ~pin_s[WAKE_IDX] & ~rad_s; // RULE11
  assign live_if.oe = q_ff.c_oe;
  assign live_if.dout = q_ff.c_out;
  assign live_if.pe = q_ff.c_pe;
  assign live_if.pu = q_ff.c_pu;
  // snapshot follows live settings until sleep begins
  pstc_hold u_hold (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .track(q_ff.st != ST_SLEEP), // RULE7
    .live(live_if),
    .held(held_if)
  );
  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    pstc_pin_t pin;
    logic ok;
    logic [31:0] wv;
    nxt_q = q_ff;
    pin = '0;
    ok = 1'b0;
    wv = '0;
    nxt_q.sy1 = {radio_events_pending, por_bod, chip_en, io_supply, pad_in};
    nxt_q.sy2 = q_ff.sy1;
    // power state, highest priority first
    if (off_s | por_s) begin
      nxt_q.rcnt = '0; // RULE12
    end else if (q_ff.rcnt != RCNT_LAST) begin
      nxt_q.rcnt = q_ff.rcnt + 1'b1;
    end
    if (off_s) begin
      nxt_q.st = ST_OFF; // RULE13 RULE1
    end else if (por_s || q_ff.rcnt != RCNT_LAST) begin
      nxt_q.st = ST_RESET; // RULE12
    end else if (!q_ff.prog) begin
      nxt_q.st = ST_DEFAULT;
    end else if (sleep_req) begin
      nxt_q.st = ST_SLEEP; // RULE11
    end else begin
      nxt_q.st = ST_ACTIVE;
    end
    // pad drive from the current state
    for (int i = 0; i < NP; i++) begin
      pin = '0;
      unique case (q_ff.st)
        ST_OFF: begin
          pin = '0; // RULE1
        end
        ST_RESET: begin
          if (i == WAKE_IDX) begin
            pin.pe = 1'b1; // RULE2
            pin.pu = 1'b1;
          end
        end
        ST_DEFAULT: begin
          if (i < MIX_LO) begin
            pin.ie = 1'b1; // RULE3
            pin.pe = 1'b1;
            pin.pu = 1'b1;
          end
        end
        ST_ACTIVE: begin
          pin = pin_drv(q_ff.c_oe[i], q_ff.c_out[i], q_ff.c_pe[i],
                        q_ff.c_pu[i]); // RULE5
        end
        ST_SLEEP: begin
          if (i == WAKE_IDX || i >= MIX_LO) begin
            pin = pin_drv(q_ff.c_oe[i], q_ff.c_out[i], q_ff.c_pe[i],
                          q_ff.c_pu[i]); // RULE8
          end
          if (i < NSW || i >= MIX_LO) begin
            pin = pin_drv(held_if.oe[i], held_if.dout[i], held_if.pe[i],
                          held_if.pu[i]); // RULE7
          end
        end
      endcase
      // analog mode removes every digital driver and pull
      if (i >= MIX_LO && (q_ff.ana[1'(i - MIX_LO)] ||
          !(q_ff.st inside {ST_ACTIVE, ST_SLEEP}))) begin
        pin = '0; // RULE4 RULE9 RULE10
      end
      nxt_q.p_oe[i] = pin.oe;
      nxt_q.p_ie[i] = pin.ie;
      nxt_q.p_pe[i] = pin.pe;
      nxt_q.p_pu[i] = pin.pu;
      nxt_q.p_out[i] = pin.dout;
    end
    nxt_q.p_ana = (q_ff.st inside {ST_ACTIVE, ST_SLEEP}) ? q_ff.ana
                                                        : ANA_RST; // RULE4
    nxt_q.radio_o = (q_ff.st == ST_ACTIVE);
    nxt_q.sleep_o = (q_ff.st == ST_SLEEP);
    // firmware settings are lost while the core is off or in reset
    if (q_ff.st inside {ST_OFF, ST_RESET}) begin
      nxt_q.prog = 1'b0;
      nxt_q.c_oe = CFG_RST;
      nxt_q.c_out = CFG_RST;
      nxt_q.c_pe = CFG_RST;
      nxt_q.c_pu = CFG_RST;
      nxt_q.ana = ANA_RST; // RULE9
    end
    ////////////////////////////////////////////////////////////////////////
    // register bus
    if (awvalid && !q_ff.aw_h && !q_ff.bv) begin
      nxt_q.aw_h = 1'b1;
      nxt_q.aw_a = awaddr;
    end
    if (wvalid && !q_ff.w_h && !q_ff.bv) begin
      nxt_q.w_h = 1'b1;
      nxt_q.w_d = wdata;
      nxt_q.w_s = wstrb;
    end
    if (q_ff.bv && bready) begin
      nxt_q.bv = 1'b0;
    end
    if (q_ff.aw_h && q_ff.w_h && !q_ff.bv) begin
      ok = !(q_ff.st inside {ST_OFF, ST_RESET});
      unique case (q_ff.aw_a)
        OFS_CTRL: begin
          wv = wr_lanes(32'(q_ff.prog), q_ff.w_d, q_ff.w_s);
          if (ok) nxt_q.prog = wv[CTRL_PROG_BIT];
        end
        OFS_OE: begin
          wv = wr_lanes(32'(q_ff.c_oe), q_ff.w_d, q_ff.w_s);
          if (ok) nxt_q.c_oe = wv[NP-1:0]; // RULE5
        end
        OFS_DOUT: begin
          wv = wr_lanes(32'(q_ff.c_out), q_ff.w_d, q_ff.w_s);
          if (ok) nxt_q.c_out = wv[NP-1:0];
        end
        OFS_PULL_EN: begin
          wv = wr_lanes(32'(q_ff.c_pe), q_ff.w_d, q_ff.w_s);
          if (ok) nxt_q.c_pe = wv[NP-1:0];
        end
        OFS_PULL_UP: begin
          wv = wr_lanes(32'(q_ff.c_pu), q_ff.w_d, q_ff.w_s);
          if (ok) nxt_q.c_pu = wv[NP-1:0];
        end
        OFS_ANA_SEL: begin
          wv = wr_lanes(32'(q_ff.ana), q_ff.w_d, q_ff.w_s);
          if (ok) nxt_q.ana = wv[NM-1:0]; // RULE9
        end
        default: begin
          ok = 1'b0;
        end
      endcase
      nxt_q.aw_h = 1'b0;
      nxt_q.w_h = 1'b0;
      nxt_q.bv = 1'b1;
      nxt_q.br = ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (q_ff.rv && rready) begin
      nxt_q.rv = 1'b0;
    end
    if (arvalid && !q_ff.rv) begin
      nxt_q.rv = 1'b1;
      nxt_q.rr = RESP_OKAY;
      nxt_q.rd = '0;
      unique case (araddr)
        OFS_CTRL: nxt_q.rd[CTRL_PROG_BIT] = q_ff.prog;
        OFS_OE: nxt_q.rd[NP-1:0] = q_ff.c_oe;
        OFS_DOUT: nxt_q.rd[NP-1:0] = q_ff.c_out;
        OFS_PULL_EN: nxt_q.rd[NP-1:0] = q_ff.c_pe;
        OFS_PULL_UP: nxt_q.rd[NP-1:0] = q_ff.c_pu;
        OFS_ANA_SEL: nxt_q.rd[NM-1:0] = q_ff.ana;
        OFS_STATUS: begin
          nxt_q.rd[STS_OFF_BIT] = (q_ff.st == ST_OFF);
          nxt_q.rd[STS_RST_BIT] = (q_ff.st == ST_RESET);
          nxt_q.rd[STS_DEF_BIT] = (q_ff.st == ST_DEFAULT);
          nxt_q.rd[STS_SLP_BIT] = (q_ff.st == ST_SLEEP);
          nxt_q.rd[STS_ACT_BIT] = (q_ff.st == ST_ACTIVE);
          nxt_q.rd[STS_WAKE_BIT] = pin_s[WAKE_IDX];
          nxt_q.rd[STS_RADIO_BIT] = rad_s;
        end
        OFS_PAD_IN: nxt_q.rd[NP-1:0] = pin_s;
        default: nxt_q.rr = RESP_SLVERR;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_ff <= '0;
      q_ff.st <= ST_OFF;
      q_ff.ana <= ANA_RST;
      q_ff.p_ana <= ANA_RST;
      // supply seen present, enable low: powered down until pins settle
      q_ff.sy1[NP] <= 1'b1;
      q_ff.sy2[NP] <= 1'b1;
    end else if (ce) begin
      q_ff <= nxt_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  assign awready = ~q_ff.aw_h & ~q_ff.bv;
  assign wready = ~q_ff.w_h & ~q_ff.bv;
  assign bvalid = q_ff.bv;
  assign bresp = q_ff.br;
  assign arready = ~q_ff.rv;
  assign rvalid = q_ff.rv;
  assign rdata = q_ff.rd;
  assign rresp = q_ff.rr;
  assign pad_oe = q_ff.p_oe;
  assign pad_out = q_ff.p_out;
  assign pad_ie = q_ff.p_ie;
  assign pad_pe = q_ff.p_pe;
  assign pad_pu = q_ff.p_pu;
  assign pad_analog = q_ff.p_ana;
  assign radio_active_state = q_ff.radio_o;
  assign sleep_enter = q_ff.sleep_o;
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_off_hiz: assert property ( // RULE1
    (ce && q_ff.st == ST_OFF) |=> (pad_oe == '0 && pad_ie == '0 &&
    pad_pe == '0)) else $error("pad active while powered down");
  chk_rst_pull: assert property ( // RULE2
    (ce && q_ff.st == ST_RESET) |=> (pad_oe == '0 && pad_ie == '0 &&
    pad_pe == (NP'(1) << WAKE_IDX) && pad_pu[WAKE_IDX]))
    else $error("wrong pads during reset pulse");
  chk_def_digital: assert property ( // RULE3
    (ce && q_ff.st == ST_DEFAULT) |=> (pad_oe[MIX_LO-1:0] == '0 &&
    &pad_ie[MIX_LO-1:0] && &pad_pe[MIX_LO-1:0] && &pad_pu[MIX_LO-1:0]))
    else $error("digital default pads wrong");
  chk_def_mixed: assert property ( // RULE4
    (ce && q_ff.st == ST_DEFAULT) |=> (pad_ie[NP-1:MIX_LO] == '0 &&
    pad_pe[NP-1:MIX_LO] == '0 && pad_analog == ANA_RST))
    else $error("mixed default pads wrong");
  chk_act_live: assert property ( // RULE5
    (ce && q_ff.st == ST_ACTIVE) |=> (pad_pe[NSW:0] ==
    $past(q_ff.c_pe[NSW:0]) && pad_out[NSW:0] == $past(q_ff.c_out[NSW:0])))
    else $error("active pads ignore settings");
  chk_ie_oppose: assert property ( // RULE6
    (ce && q_ff.st inside {ST_ACTIVE, ST_SLEEP}) |=>
    (pad_ie[NSW:0] == ~pad_oe[NSW:0])) else $error("input not opposite");
  chk_ret_hold: assert property ( // RULE7
    (ce && q_ff.st == ST_SLEEP) |=> (pad_oe[NSW-1:0] ==
    $past(held_if.oe[NSW-1:0]) && pad_pu[NSW-1:0] ==
    $past(held_if.pu[NSW-1:0]))) else $error("retention not applied");
  chk_wake_live: assert property ( // RULE8
    (ce && q_ff.st == ST_SLEEP) |=> (pad_oe[WAKE_IDX] ==
    $past(q_ff.c_oe[WAKE_IDX]))) else $error("wake pad retained");
  chk_ana_off: assert property ( // RULE9
    (ce && q_ff.st == ST_ACTIVE && q_ff.ana[0]) |=> (!pad_oe[MIX_LO] &&
    !pad_ie[MIX_LO] && !pad_pe[MIX_LO])) else $error("analog pad driven");
  chk_ana_wins: assert property ( // RULE10
    (ce && q_ff.st == ST_SLEEP && q_ff.ana[1]) |=> (!pad_oe[MIX_LO+1] &&
    !pad_pe[MIX_LO+1])) else $error("retention beat analog mode");
  chk_wake_block: assert property ( // RULE11
    (ce && pin_s[WAKE_IDX]) |=> q_ff.st != ST_SLEEP)
    else $error("slept with wake pin high");
  chk_rst_len: assert property ( // RULE12
    (ce && !off_s && q_ff.st == ST_RESET && q_ff.rcnt != RCNT_LAST) |=>
    q_ff.st == ST_RESET) else $error("reset pulse too short");
  chk_off_first: assert property ( // RULE13
    (ce && off_s) |=> q_ff.st == ST_OFF) else $error("off not first");
endmodule

//--- tb/pstc_board.sv
// Purpose: board-side model of the pads: drivers, pulls, wake pin
// Assumes: external drive only where ext_en is set
// Notes: an undriven pad without pull toggles every cycle
`timescale 1ns/1ps
module pstc_board (
  input wire logic aclk,
  input wire logic [pstc_pkg::NP-1:0] pad_out,
  input wire logic [pstc_pkg::NP-1:0] pad_oe,
  input wire logic [pstc_pkg::NP-1:0] pad_pe,
  input wire logic [pstc_pkg::NP-1:0] pad_pu,
  input wire logic [pstc_pkg::NP-1:0] ext_en,
  input wire logic [pstc_pkg::NP-1:0] ext_val,
  output logic [pstc_pkg::NP-1:0] pad_in
);
  import pstc_pkg::*;
  logic tog = 1'b0;
  always @(posedge aclk) begin
    tog <= ~tog;
  end
  // wake pin level comes from the board switch
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else if (pad_pe[i])
        pad_in[i] = pad_pu[i];
      else
        pad_in[i] = tog ^ i[0];
    end
  end
endmodule

//--- tb/tb.sv
// Purpose: self-checking bench for the pad state controller
// Assumes: short reset pulse count, ce dropped once to freeze state
// Notes: register access through AXI4-Lite tasks
`timescale 1ns/1ps
module tb;
  import pstc_pkg::*;
  localparam int RC = 16;
  localparam logic [14:0] OE_A = 15'h40a5;
  localparam logic [14:0] DO_A = 15'h7f0f;
  localparam logic [14:0] PE_A = 15'h7f5a;
  localparam logic [14:0] PU_A = 15'h2c3c;
  localparam logic [14:0] WK = 15'h1000;
  localparam logic [14:0] DIG = 15'h1fff;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, pad_analog;
  logic io_supply, chip_en, por_bod, radio_events_pending, ce;
  logic radio_active_state, sleep_enter;
  logic [14:0] pad_in, pad_out, pad_oe, pad_ie, pad_pe, pad_pu;
  logic [14:0] ext_en, ext_val;
  int n_errors = 0;
  int compares = 0;
  pstc_top #(.RST_CYCLES(RC)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .io_supply(io_supply),
    .chip_en(chip_en), .por_bod(por_bod),
    .radio_events_pending(radio_events_pending), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_ie(pad_ie),
    .pad_pe(pad_pe), .pad_pu(pad_pu), .pad_analog(pad_analog),
    .radio_active_state(radio_active_state), .sleep_enter(sleep_enter));
  pstc_board i_board (.aclk(aclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pe(pad_pe), .pad_pu(pad_pu), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(pad_in));
  ////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic pads(input logic [14:0] oe, ie, pe, pu);
    chk("pad_oe", {17'h0, oe}, {17'h0, pad_oe});
    chk("pad_ie", {17'h0, ie}, {17'h0, pad_ie});
    chk("pad_pe", {17'h0, pe}, {17'h0, pad_pe});
    chk("pad_pu", {17'h0, pu}, {17'h0, pad_pu & pad_pe});
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, tr;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tr);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
    chk("rdata", ed, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_bringup();
    chk("pad_analog", 32'h3, {30'h0, pad_analog});
    pads(15'h0, 15'h0, 15'h0, 15'h0);
    chip_en <= 1'b1;
    cyc(6);
    pads(15'h0, 15'h0, WK, WK);
    wr(OFS_OE, 32'h7fff, RESP_SLVERR);
    cyc(RC + 6);
    pads(15'h0, DIG, DIG, DIG);
    chk("pad_analog", 32'h3, {30'h0, pad_analog});
  endtask
  task automatic t_program();
    wr(OFS_OE, {17'h0, OE_A}, RESP_OKAY);
    wr(OFS_DOUT, {17'h0, DO_A}, RESP_OKAY);
    wr(OFS_PULL_EN, {17'h0, PE_A}, RESP_OKAY);
    wr(OFS_PULL_UP, {17'h0, PU_A}, RESP_OKAY);
    wr(OFS_ANA_SEL, 32'h0, RESP_OKAY);
    cyc(2);
    pads(15'h0, DIG, DIG, DIG);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    cyc(6);
    chk("active", 32'h1, {31'h0, radio_active_state});
    pads(OE_A, ~OE_A, PE_A, PU_A & PE_A);
    chk("pad_out", {17'h0, DO_A & OE_A}, {17'h0, pad_out & OE_A});
    chk("pad_analog", 32'h0, {30'h0, pad_analog});
    rd(OFS_OE, {17'h0, OE_A}, RESP_OKAY);
    rd(OFS_STATUS, 32'h30, RESP_OKAY);
    rd(OFS_PAD_IN, {17'h0, (DO_A & OE_A) | WK |
       (PU_A & PE_A & ~OE_A & ~WK)}, RESP_OKAY);
    rd(5'h02, 32'h0, RESP_SLVERR);
    wr(OFS_STATUS, 32'h0, RESP_SLVERR);
  endtask
  task automatic t_sleep();
    logic [14:0] oe, pe;
    oe = OE_A & 15'h4fff;
    pe = PE_A & 15'h4fff;
    ext_val[WAKE_IDX] <= 1'b0;
    cyc(6);
    chk("sleep", 32'h1, {31'h0, sleep_enter});
    wr(OFS_OE, 32'h0, RESP_OKAY);
    wr(OFS_PULL_EN, 32'h0, RESP_OKAY);
    wr(OFS_PULL_UP, 32'h7fff, RESP_OKAY);
    wr(OFS_ANA_SEL, 32'h1, RESP_OKAY);
    cyc(4);
    chk("pad_analog", 32'h1, {30'h0, pad_analog});
    pads(oe, ~oe & 15'h5fff, pe, PU_A & pe);
    chk("pad_out", {17'h0, DO_A & oe}, {17'h0, pad_out & oe});
    wstrb <= 4'h2;
    wr(OFS_DOUT, 32'h0, RESP_OKAY);
    wstrb <= 4'hf;
    rd(OFS_DOUT, {17'h0, DO_A & 15'h00ff}, RESP_OKAY);
    radio_events_pending <= 1'b1;
    cyc(6);
    chk("active", 32'h1, {31'h0, radio_active_state});
    pads(15'h0, 15'h5fff, 15'h0, 15'h0);
    ce <= 1'b0;
    radio_events_pending <= 1'b0;
    cyc(8);
    chk("frozen", 32'h1, {31'h0, radio_active_state});
    ce <= 1'b1;
    cyc(6);
    chk("sleep", 32'h1, {31'h0, sleep_enter});
  endtask
  task automatic t_reset_off();
    por_bod <= 1'b1;
    cyc(6);
    pads(15'h0, 15'h0, WK, WK);
    por_bod <= 1'b0;
    cyc(RC - 4);
    pads(15'h0, 15'h0, WK, WK);
    cyc(12);
    pads(15'h0, DIG, DIG, DIG);
    por_bod <= 1'b1;
    chip_en <= 1'b0;
    cyc(6);
    pads(15'h0, 15'h0, 15'h0, 15'h0);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 5'h0;
    araddr = 5'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    io_supply = 1'b1;
    ce = 1'b1;
    chip_en = 1'b0;
    por_bod = 1'b0;
    radio_events_pending = 1'b0;
    ext_en = WK;
    ext_val = WK;
    cyc(5);
    aresetn <= 1'b1;
    cyc(6);
    t_bringup();
    t_program();
    t_sleep();
    t_reset_off();
    summarize();
  end
  initial begin
    cyc(3000);
    n_errors++;
    summarize();
  end
endmodule
